//--- hw/ee_prog_pkg.sv
// constants and types shared by the data eeprom access controller
package ee_prog_pkg;

  // register map
  localparam logic [15:0] CSR_ADDR   = 16'h0030;
  localparam logic [7:0]  CSR_RESET  = 8'h00;
  localparam int          LAT_BIT    = 1;
  localparam int          PGM_BIT    = 0;

  // eeprom window in the data space
  localparam logic [15:0] EE_BASE    = 16'h1000;
  localparam int          EE_BYTES   = 128;
  localparam int          EE_AW      = 7;
  localparam int          ROW_BYTES  = 32;
  localparam int          COL_BITS   = 5;
  localparam int          ROW_BITS   = 2;
  localparam logic [7:0]  LATCH_FREE = 8'hff;

  // programming cycle timing
  localparam int          CLK_MHZ      = 125;
  localparam int          PROG_TIME_US = 5000;
  localparam int          PROG_CYC_DEF = PROG_TIME_US * CLK_MHZ;
  localparam int          CNT_W        = 24;
  localparam logic [23:0] CNT_ZERO     = 24'h000000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_WAIT = 2'b11,
    ST_HALT = 2'b10
  } ee_state_type;

endpackage

//--- hw/data_eeprom_program_ctrl.sv
// data eeprom access controller: array, row latches, control/status register, power modes
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps

module data_eeprom_program_ctrl
  import ee_prog_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC_DEF
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        ext_access_i,
  input  wire logic        wait_req_i,
  input  wire logic        halt_i,
  input  wire logic        protect_i,
  output logic      [7:0]  rdata_o,
  output logic             rdata_drive_o,
  output logic             wait_ack_o,
  output logic             erase_all_o
);

  function automatic logic ee_hit(input logic [15:0] a);
    ee_hit = (a[15:EE_AW] == EE_BASE[15:EE_AW]);
  endfunction

  function automatic logic csr_hit(input logic [15:0] a);
    csr_hit = (a == CSR_ADDR);
  endfunction

  logic [7:0]          mem [EE_BYTES];
  logic [7:0]          latch_data [ROW_BYTES];
  logic [ROW_BYTES-1:0] latch_valid;
  logic [ROW_BITS-1:0] row;
  logic                latch_write_mode;
  logic                program_start;
  logic                lat_prev;
  ee_state_type        state;
  ee_state_type        next_state;
  logic [CNT_W-1:0]    cnt;
  logic                prot_s1;
  logic                prot_s2;
  logic                prot_s3;
  logic                protect;
  logic                prog_done;
  logic                latch_clr;
  logic                blocked;
  logic                csr_wr;
  logic                latch_wr;

  // option bit comes from outside this clock, filtered by agreement of stages two and three
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      prot_s1 <= 1'b0;
      prot_s2 <= 1'b0;
      prot_s3 <= 1'b0;
    end else begin
      prot_s1 <= protect_i;
      prot_s2 <= prot_s1;
      prot_s3 <= prot_s2;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      protect     <= 1'b0;
      erase_all_o <= 1'b0;
    end else begin
      erase_all_o <= 1'b0;
      if (prot_s2 == prot_s3) begin
        protect <= prot_s2;
        // removing protection wipes the whole array first; the row latches are kept
        erase_all_o <= protect & ~prot_s2;
      end
    end
  end

  assign blocked   = protect & ext_access_i;
  assign csr_wr    = wr_i & csr_hit(addr_i) & ~blocked;
  // writes only land in latches in write mode
  assign latch_wr  = wr_i & ee_hit(addr_i) & latch_write_mode & ~blocked;
  assign prog_done = (state == ST_PROG) & program_start & ~halt_i
                     & (cnt == CNT_W'(PROG_CYCLES - 1));
  assign latch_clr = prog_done | (lat_prev & ~latch_write_mode);

  // control/status register
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      latch_write_mode <= CSR_RESET[LAT_BIT];
      program_start    <= CSR_RESET[PGM_BIT];
    end else if (prog_done) begin
      latch_write_mode <= 1'b0;
      program_start    <= 1'b0;
    end else if (halt_i) begin
      program_start <= 1'b0;
    end else if (csr_wr) begin
      if (wdata_i[LAT_BIT]) begin
        latch_write_mode <= 1'b1;
      end else if (!program_start) begin
        latch_write_mode <= 1'b0;
      end
      if (wdata_i[PGM_BIT]) begin
        // start only once write mode is already in force
        program_start <= program_start | latch_write_mode;
      end else begin
        program_start <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      lat_prev <= 1'b0;
    end else begin
      lat_prev <= latch_write_mode;
    end
  end

  // row latches, one byte per column; a free latch holds all ones so merging is a plain and
  genvar gc;
  generate
    for (gc = 0; gc < ROW_BYTES; gc++) begin : g_latch
      always_ff @(posedge clock_i) begin
        if (!nrst_i || latch_clr) begin
          latch_data[gc]  <= LATCH_FREE;
          latch_valid[gc] <= 1'b0;
        end else if (latch_wr && addr_i[COL_BITS-1:0] == COL_BITS'(gc)) begin
          latch_data[gc]  <= latch_data[gc] & wdata_i;
          latch_valid[gc] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      row <= '0;
    end else if (latch_wr) begin
      row <= addr_i[EE_AW-1:COL_BITS];
    end
  end

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (halt_i) begin
          next_state = ST_HALT;
        end else if (program_start) begin
          next_state = ST_PROG;
        end else if (wait_req_i) begin
          next_state = ST_WAIT;
        end
      end
      ST_PROG: begin
        if (halt_i) begin
          next_state = ST_HALT;
        end else if (!program_start) begin
          next_state = ST_IDLE;
        end else if (prog_done) begin
          next_state = wait_req_i ? ST_WAIT : ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (halt_i) begin
          next_state = ST_HALT;
        end else if (!wait_req_i) begin
          next_state = ST_IDLE;
        end
      end
      ST_HALT: begin
        if (!halt_i) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wait_ack_o <= 1'b0;
    end else begin
      wait_ack_o <= (next_state == ST_WAIT);
    end
  end

  // cycle timer clears to zero whenever the state is not ST_PROG, so it restarts from zero after any abort
  always_ff @(posedge clock_i) begin
    if (!nrst_i || state != ST_PROG || prog_done) begin
      cnt <= CNT_ZERO;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // array: commit the latched bytes of the row at cycle end, mass erase on protection removal
  always_ff @(posedge clock_i) begin
    if (erase_all_o) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (prog_done) begin
      for (int c = 0; c < ROW_BYTES; c++) begin
        if (latch_valid[c]) begin
          mem[{row, COL_BITS'(c)}] <= latch_data[c];
        end
      end
    end
  end

  // read port: latches have no path here at all
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rdata_o       <= 8'h00;
      rdata_drive_o <= 1'b0;
    end else begin
      rdata_o       <= 8'h00;
      rdata_drive_o <= 1'b0;
      if (rd_i && csr_hit(addr_i)) begin
        rdata_o       <= {6'h00, latch_write_mode, program_start};
        rdata_drive_o <= 1'b1;
      end else if (rd_i && ee_hit(addr_i) && !latch_write_mode && !blocked) begin
        rdata_o       <= mem[addr_i[EE_AW-1:0]];
        rdata_drive_o <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  done_clears_a: assert property (prog_done |=> !latch_write_mode && !program_start)
    else $error("cycle end left control bits set");
  latch_empty_a: assert property (prog_done |=> latch_valid == '0)
    else $error("latches not cleared after cycle");
  lat_read_a: assert property (rd_i && ee_hit(addr_i) && latch_write_mode |=> !rdata_drive_o)
    else $error("bus driven during write mode read");
  rom_read_a: assert property (rd_i && ee_hit(addr_i) && !latch_write_mode && !blocked
      |=> rdata_drive_o && rdata_o == mem[$past(addr_i[EE_AW-1:0])])
    else $error("read mode read returned wrong data");
  ignore_write_a: assert property (wr_i && ee_hit(addr_i) && !latch_write_mode && !latch_clr
      |=> latch_valid == $past(latch_valid))
    else $error("write in read mode was latched");
  reserved_zero_a: assert property (rd_i && csr_hit(addr_i) |=> rdata_o[7:2] == 6'h00)
    else $error("reserved status bits read nonzero");
  and_merge_a: assert property (latch_wr && !latch_clr
      |=> latch_data[$past(addr_i[COL_BITS-1:0])]
          == ($past(latch_data[addr_i[COL_BITS-1:0]]) & $past(wdata_i)))
    else $error("latch merge is not a bitwise and");
  halt_stop_a: assert property (halt_i && !prog_done |=> !program_start && state == ST_HALT)
    else $error("halt did not stop the cycle");
  wait_idle_a: assert property (state == ST_IDLE && wait_req_i && !halt_i && !program_start
      |=> wait_ack_o && state == ST_WAIT)
    else $error("idle block did not enter wait");
  wait_finish_a: assert property (state == ST_PROG && wait_req_i && program_start && !halt_i && !prog_done
      |=> state == ST_PROG)
    else $error("wait cut a running cycle short");
  lat_hold_a: assert property (csr_wr && !wdata_i[LAT_BIT] && wdata_i[PGM_BIT] && program_start
      && !prog_done && !halt_i |=> latch_write_mode)
    else $error("mode bit cleared while programming");
  abort_clear_a: assert property (csr_wr && !wdata_i[PGM_BIT] && state == ST_PROG && program_start
      && !prog_done && !halt_i
      |=> !program_start ##1 state == ST_IDLE)
    else $error("clearing start bit did not abort");
  // reset checks must not be switched off by the reset they watch
  reset_abort_a: assert property (@(posedge clock_i) disable iff (1'b0)
      !nrst_i |=> state == ST_IDLE && !program_start)
    else $error("reset did not abort programming");
  reset_csr_a: assert property (@(posedge clock_i) disable iff (1'b0)
      !nrst_i |=> !latch_write_mode && !program_start && !rdata_drive_o)
    else $error("status register not cleared by reset");

  // protection and mass erase
  protect_read_a: assert property (rd_i && ee_hit(addr_i) && blocked
      |=> !rdata_drive_o)
    else $error("protected array was read out");
  protect_csr_a: assert property (wr_i && csr_hit(addr_i) && blocked && !prog_done && !halt_i
      |=> latch_write_mode == $past(latch_write_mode) && program_start == $past(program_start))
    else $error("protected status register was written");
  protect_latch_a: assert property (wr_i && ee_hit(addr_i) && blocked && !latch_clr
      |=> latch_valid == $past(latch_valid))
    else $error("protected latch was written");
  erase_mem_a: assert property (erase_all_o
      |=> mem[0] == 8'h00 && mem[EE_BYTES-1] == 8'h00)
    else $error("array not erased on protection removal");
  erase_pulse_a: assert property (erase_all_o
      |=> !erase_all_o)
    else $error("erase request longer than one cycle");

  // bus answers
  unmapped_read_a: assert property (rd_i && !ee_hit(addr_i) && !csr_hit(addr_i)
      |=> !rdata_drive_o && rdata_o == 8'h00)
    else $error("unmapped read was answered");
  read_stands_a: assert property (!rd_i
      |=> !rdata_drive_o && rdata_o == 8'h00)
    else $error("read data held past its cycle");
  csr_bits_a: assert property (rd_i && csr_hit(addr_i)
      |=> rdata_drive_o && rdata_o[LAT_BIT] == $past(latch_write_mode)
          && rdata_o[PGM_BIT] == $past(program_start))
    else $error("status read does not show control bits");

  // control bits and latches
  lat_set_a: assert property (csr_wr && wdata_i[LAT_BIT] && !prog_done && !halt_i
      |=> latch_write_mode)
    else $error("mode bit not set by software");
  start_needs_mode_a: assert property (csr_wr && wdata_i[PGM_BIT] && !latch_write_mode
      && !prog_done && !halt_i |=> !program_start)
    else $error("cycle started outside write mode");
  start_sets_a: assert property (csr_wr && wdata_i[PGM_BIT] && latch_write_mode
      && !prog_done && !halt_i |=> program_start)
    else $error("start bit not set in write mode");
  latch_mark_a: assert property (latch_wr && !latch_clr
      |=> latch_valid[$past(addr_i[COL_BITS-1:0])])
    else $error("latched byte not marked");
  row_track_a: assert property (latch_wr
      |=> row == $past(addr_i[EE_AW-1:COL_BITS]))
    else $error("row not taken from last latched write");
  mode_fall_a: assert property (lat_prev && !latch_write_mode
      |=> latch_valid == '0)
    else $error("latches kept after mode bit fell");

  // sequencer and timer
  timer_step_a: assert property (state == ST_PROG && program_start && !prog_done && !halt_i
      |=> cnt == $past(cnt) + 1'b1)
    else $error("cycle timer did not advance");
  timer_idle_a: assert property (state != ST_PROG
      |=> cnt == CNT_ZERO)
    else $error("cycle timer not cleared outside a cycle");
  wait_ack_a: assert property (wait_ack_o == (state == ST_WAIT))
    else $error("wait acknowledge disagrees with state");
  wait_keep_a: assert property (state == ST_WAIT && wait_req_i && !halt_i
      |=> state == ST_WAIT)
    else $error("wait state left while requested");
  halt_hold_a: assert property (state == ST_HALT && halt_i
      |=> state == ST_HALT && !program_start)
    else $error("halt state left while halted");

  prog_done_c: cover property (prog_done);
  done_to_wait_c: cover property (prog_done && wait_req_i ##1 state == ST_WAIT);
  rom_read_c: cover property (rdata_drive_o && lat_prev == 1'b0 ##1 latch_write_mode);
  erase_c: cover property (erase_all_o);
  halt_abort_c: cover property (halt_i && state == ST_PROG);

endmodule

//--- sim/cpu_bus_model.sv
// cpu side bus master for the eeprom controller
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        clock_i,
  input  wire logic [7:0]  rdata_i,
  input  wire logic        drive_i,
  output logic      [15:0] addr_o,
  output logic      [7:0]  wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // released lines show the inverse, never a stale copy
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
    v = drive_i;
  endtask
endmodule

//--- sim/data_eeprom_program_ctrl_tb.sv
// self-checking bench for the data eeprom access controller
`timescale 1ns/1ps
module data_eeprom_program_ctrl_tb;
  import ee_prog_pkg::*;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        ext_access_i = 1'b0;
  logic        wait_req_i = 1'b0;
  logic        halt_i = 1'b0;
  logic        protect_i = 1'b0;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata_o;
  logic        wr;
  logic        rd;
  logic        rdata_drive_o;
  logic        wait_ack_o;
  logic        erase_all_o;
  int          errors = 0;
  int          comparisons = 0;
  logic [31:0] seed = 32'hfdae;
  int          mem [128];
  bit          known [128];
  int          lat [32];
  bit          used [32];
  always #4 clock_i = ~clock_i;
  cpu_bus_model bus (.clock_i(clock_i), .rdata_i(rdata_o), .drive_i(rdata_drive_o), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  // short cycle keeps the run small
  data_eeprom_program_ctrl #(.PROG_CYCLES(20)) dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .ext_access_i(ext_access_i), .wait_req_i(wait_req_i),
    .halt_i(halt_i), .protect_i(protect_i), .rdata_o(rdata_o), .rdata_drive_o(rdata_drive_o),
    .wait_ack_o(wait_ack_o), .erase_all_o(erase_all_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic drv, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    bus.rd(a, d, v);
    chk("drive", {7'h00, v}, {7'h00, drv});
    chk("rdata", d, exp);
  endtask
  task automatic start(input int r, input int n);
    logic [31:0] x;
    bus.wr(CSR_ADDR, 8'hfe);
    rchk(CSR_ADDR, 1'b1, 8'h02);
    rchk(EE_BASE + 16'(r * 32), 1'b0, 8'h00);
    for (int i = 0; i < n; i++) begin
      x = rnd();
      lat[x[4:0]] &= x[15:8];
      used[x[4:0]] = 1'b1;
      bus.wr(EE_BASE + 16'(r * 32 + x[4:0]), x[15:8]);
    end
    bus.wr(CSR_ADDR, 8'h03);
    rchk(CSR_ADDR, 1'b1, 8'h03);
  endtask
  task automatic finish(input int r);
    logic [7:0] d;
    logic       v;
    d = 8'h01;
    for (int k = 0; k < 40 && d !== 8'h00; k++)
      bus.rd(CSR_ADDR, d, v);
    chk("csr_done", d, 8'h00);
    for (int c = 0; c < 32; c++) begin
      if (used[c]) begin
        mem[r * 32 + c] = lat[c];
        known[r * 32 + c] = 1'b1;
      end
      lat[c] = 255;
      used[c] = 1'b0;
      if (known[r * 32 + c])
        rchk(EE_BASE + 16'(r * 32 + c), 1'b1, 8'(mem[r * 32 + c]));
    end
  endtask
  // an interrupted row holds no guaranteed data
  task automatic abandon(input int r);
    for (int c = 0; c < 32; c++) begin
      known[r * 32 + c] = 1'b0;
      lat[c] = 255;
      used[c] = 1'b0;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    wrap_up();
  end
  initial begin
    foreach (lat[c]) lat[c] = 255;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    rchk(CSR_ADDR, 1'b1, CSR_RESET);
    rchk(16'h0031, 1'b0, 8'h00);
    wait_req_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk("wait_idle", {7'h00, wait_ack_o}, 8'h01);
    wait_req_i <= 1'b0;
    start(1, 40);
    wait_req_i <= 1'b1;
    chk("wait_busy", {7'h00, wait_ack_o}, 8'h00);
    finish(1);
    chk("wait_after", {7'h00, wait_ack_o}, 8'h01);
    wait_req_i <= 1'b0;
    for (int c = 0; c < 32; c++)
      bus.wr(EE_BASE + 16'(32 + c), 8'h00);
    finish(1);
    start(1, 40);
    finish(1);
    start(2, 8);
    bus.wr(CSR_ADDR, 8'h02);
    rchk(CSR_ADDR, 1'b1, 8'h02);
    bus.wr(CSR_ADDR, 8'h00);
    rchk(CSR_ADDR, 1'b1, 8'h00);
    abandon(2);
    start(2, 8);
    finish(2);
    start(3, 8);
    halt_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    halt_i <= 1'b0;
    rchk(CSR_ADDR, 1'b1, 8'h02);
    bus.wr(CSR_ADDR, 8'h00);
    abandon(3);
    start(0, 8);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    rchk(CSR_ADDR, 1'b1, 8'h00);
    abandon(0);
    protect_i <= 1'b1;
    ext_access_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    rchk(EE_BASE + 16'h0020, 1'b0, 8'h00);
    bus.wr(CSR_ADDR, 8'h02);
    rchk(CSR_ADDR, 1'b1, 8'h00);
    ext_access_i <= 1'b0;
    protect_i <= 1'b0;
    for (int k = 0; k < 10 && erase_all_o !== 1'b1; k++) begin
      @(posedge clock_i);
      #1;
    end
    chk("erase_all", {7'h00, erase_all_o}, 8'h01);
    foreach (mem[i]) mem[i] = 0;
    foreach (known[i]) known[i] = 1'b1;
    finish(1);
    wrap_up();
  end
endmodule
